// File: bgd_host_ctrl.sv
// Added by the designer: the register offsets and the APB register port.
module bgd_host_ctrl import bgd_pkg::*; #(
   parameter int DUTY_W = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power stage side
   input wire logic supply_good_pin,
   output bgd_pins_s pins
);
   generate
      if (DUTY_W < 2 || DUTY_W > 16) begin : g_bad_width
         $error("bgd_host_ctrl: DUTY_W must be 2..16");
      end
   endgenerate

   // =====================================================
   // supply good synchroniser
   // =====================================================
   logic sg_meta;
   logic sg_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sg_meta <= 1'b0;
         sg_sync <= 1'b0;
      end else begin
         sg_meta <= supply_good_pin;
         sg_sync <= sg_meta;
      end
   end

   // =====================================================
   // register file
   // =====================================================
   logic [1:0] ctrl;
   logic [DUTY_W-1:0] period;
   logic [DUTY_W-1:0] duty_tgt;
   logic [DUTY_W-1:0] step;
   logic [1:0] next_ctrl;
   logic [DUTY_W-1:0] next_period;
   logic [DUTY_W-1:0] next_duty_tgt;
   logic [DUTY_W-1:0] next_step;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   bgd_state_e state;
   bgd_state_e next_state;
   logic [DLY_W-1:0] dly;
   logic [DLY_W-1:0] next_dly;
   logic [DUTY_W-1:0] cur_duty;
   logic [DUTY_W-1:0] next_cur_duty;
   logic mode_ccm;
   logic next_mode_ccm;
   bgd_pins_s next_pins;
   logic gen_pwm;
   logic gen_end;
   logic gen_en;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFS_CTRL) || (a == OFS_PERIOD) ||
                (a == OFS_DUTY) || (a == OFS_STEP) ||
                (a == OFS_STATUS);
   endfunction : addr_ok

   logic wr_take;
   assign wr_take = psel && penable && pready && pwrite;

   always_comb begin
      next_ctrl = ctrl;
      next_period = period;
      next_duty_tgt = duty_tgt;
      next_step = step;
      next_prdata = prdata;
      // error flag stands with pready only, never into the idle cycle
      next_pslverr = 1'b0;
      // pready is raised for the access phase only: one wait-free beat
      next_pready = psel && !penable;
      if (psel && !penable) begin
         next_pslverr = !addr_ok(paddr);
         next_prdata = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               OFS_CTRL: next_prdata[1:0] = ctrl;
               OFS_PERIOD: next_prdata[DUTY_W-1:0] = period;
               OFS_DUTY: next_prdata[DUTY_W-1:0] = duty_tgt;
               OFS_STEP: next_prdata[DUTY_W-1:0] = step;
               OFS_STATUS: begin
                  next_prdata[ST_STATE_LSB +: 3] = state;
                  next_prdata[ST_SUPPLY] = sg_sync;
                  next_prdata[ST_MODE_CCM] = mode_ccm;
                  next_prdata[ST_DUTY_LSB +: DUTY_W] = cur_duty;
               end
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end
      if (wr_take) begin
         case (paddr)
            OFS_CTRL: next_ctrl = pwdata[1:0];
            OFS_PERIOD: next_period = pwdata[DUTY_W-1:0];
            OFS_DUTY: next_duty_tgt = pwdata[DUTY_W-1:0];
            OFS_STEP: next_step = pwdata[DUTY_W-1:0];
            default: next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         period <= PERIOD_RESET[DUTY_W-1:0];
         duty_tgt <= DUTY_RESET[DUTY_W-1:0];
         step <= STEP_RESET[DUTY_W-1:0];
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         period <= next_period;
         duty_tgt <= next_duty_tgt;
         step <= next_step;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // =====================================================
   // sequencer
   // =====================================================
   function automatic logic [DUTY_W-1:0] ramp(
      input logic [DUTY_W-1:0] cur,
      input logic [DUTY_W-1:0] stp,
      input logic [DUTY_W-1:0] tgt);
      logic [DUTY_W:0] sum;
      sum = {1'b0, cur} + {1'b0, stp};
      if (sum >= {1'b0, tgt}) begin
         ramp = tgt;
      end else begin
         ramp = sum[DUTY_W-1:0];
      end
   endfunction : ramp

   always_comb begin
      next_state = state;
      next_dly = dly;
      next_cur_duty = cur_duty;
      next_mode_ccm = mode_ccm;
      case (state)
         ST_OFF: begin
            next_cur_duty = '0;
            // pulses only once the stage reports its supply up
            if (ctrl[CTRL_RUN] && sg_sync) begin
               next_mode_ccm = ctrl[CTRL_CCM];
               next_dly = DLY_W'(ENABLE_CYC - 1);
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // the stage ignores pulses until its enable delay ends
            if (!ctrl[CTRL_RUN] || !sg_sync) begin
               next_dly = DLY_W'(SHUTDOWN_CYC - 1);
               next_state = ST_STOP;
            end else if (dly == '0) begin
               next_state = ST_SOFT;
            end else begin
               next_dly = dly - DLY_W'(1);
            end
         end
         ST_SOFT: begin
            if (!ctrl[CTRL_RUN] || !sg_sync) begin
               next_dly = DLY_W'(SHUTDOWN_CYC - 1);
               next_state = ST_STOP;
            end else if (cur_duty >= duty_tgt) begin
               next_cur_duty = duty_tgt;
               next_state = ST_RUN;
            end else if (gen_end) begin
               // one step per switching period limits in-rush
               next_cur_duty = ramp(cur_duty, step, duty_tgt);
            end
         end
         ST_RUN: begin
            if (!ctrl[CTRL_RUN] || !sg_sync) begin
               next_dly = DLY_W'(SHUTDOWN_CYC - 1);
               next_state = ST_STOP;
            end else if (gen_end) begin
               next_cur_duty = duty_tgt;
            end
         end
         ST_STOP: begin
            next_cur_duty = '0;
            // mode pin floated; no restart before shutdown settles
            if (dly == '0) begin
               next_state = ST_OFF;
            end else begin
               next_dly = dly - DLY_W'(1);
            end
         end
         default: begin
            next_state = ST_OFF;
            next_cur_duty = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_OFF;
         dly <= '0;
         cur_duty <= '0;
         mode_ccm <= 1'b0;
      end else begin
         state <= next_state;
         dly <= next_dly;
         cur_duty <= next_cur_duty;
         mode_ccm <= next_mode_ccm;
      end
   end

   // =====================================================
   // pulse generator and pin drive
   // =====================================================
   assign gen_en = (state == ST_SOFT) || (state == ST_RUN);

   bgd_pwm_gen #(.WIDTH(DUTY_W)) u_pwm (
      .pclk(pclk),
      .presetn(presetn),
      .enable(gen_en),
      .period(period),
      .duty(cur_duty),
      .pwm(gen_pwm),
      .period_end(gen_end)
   );

   always_comb begin
      next_pins.pwm_o = 1'b0;
      next_pins.pwm_oe = 1'b0;
      next_pins.mode_o = 1'b0;
      next_pins.mode_oe = 1'b0;
      case (next_state)
         ST_WAKE: begin
            // drive the mode pin out of its window: high ccm, low dcm
            next_pins.mode_o = next_mode_ccm;
            next_pins.mode_oe = 1'b1;
         end
         ST_SOFT, ST_RUN: begin
            next_pins.mode_o = mode_ccm;
            next_pins.mode_oe = 1'b1;
            // pulse pin floats (both gates off) until switching starts
            next_pins.pwm_o = gen_pwm;
            next_pins.pwm_oe = 1'b1;
         end
         default: begin
            // floating mode pin is shutdown
            next_pins.mode_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= '0;
      end else begin
         pins <= next_pins;
      end
   end
endmodule : bgd_host_ctrl

// File: bgd_pkg.sv
// Contract
// - no pulses before supply good reported
// - ramp duty through soft start at start
// - release mode pin, shutdown after 2.5us
// - pull mode low, enable after 5us (the code drives mode high in ccm, low only in dcm)
package bgd_pkg;
   // =====================================================
   // clock and timing
   // =====================================================
   localparam int CLK_PERIOD_NS = 4;
   localparam int SHUTDOWN_DELAY_NS = 2500;
   localparam int ENABLE_DELAY_NS = 5000;
   // least times, rounded up to whole cycles
   localparam int SHUTDOWN_CYC =
      (SHUTDOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ENABLE_CYC =
      (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_W = 12;

   // =====================================================
   // register map
   // =====================================================
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_DUTY = 8'h08;
   localparam logic [7:0] OFS_STEP = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_CCM = 1;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_SUPPLY = 3;
   localparam int ST_MODE_CCM = 4;
   localparam int ST_DUTY_LSB = 16;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [15:0] PERIOD_RESET = 16'h00F9;
   localparam logic [15:0] DUTY_RESET = 16'h0000;
   localparam logic [15:0] STEP_RESET = 16'h0001;

   // =====================================================
   // types
   // =====================================================
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_WAKE = 3'b001,
      ST_SOFT = 3'b011,
      ST_RUN = 3'b010,
      ST_STOP = 3'b110
   } bgd_state_e;

   // pin bundle toward the power stage; oe low floats the pin
   typedef struct packed {
      logic pwm_o;
      logic pwm_oe;
      logic mode_o;
      logic mode_oe;
   } bgd_pins_s;
endpackage : bgd_pkg

// File: bgd_pwm_gen.sv
module bgd_pwm_gen import bgd_pkg::*; #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic enable,
   input wire logic [WIDTH-1:0] period,
   input wire logic [WIDTH-1:0] duty,
   // outputs
   output logic pwm,
   output logic period_end
);
   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("bgd_pwm_gen: WIDTH must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] next_cnt;
   logic next_pwm;
   logic next_period_end;

   // =====================================================
   // counter and compare
   // =====================================================
   always_comb begin
      next_cnt = '0;
      next_pwm = 1'b0;
      next_period_end = 1'b0;
      if (enable) begin
         if (cnt >= period) begin
            next_cnt = '0;
            next_period_end = 1'b1;
         end else begin
            next_cnt = cnt + WIDTH'(1);
         end
         // duty is sampled per cycle; the ramp only moves at wrap
         next_pwm = (next_cnt < duty);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         pwm <= 1'b0;
         period_end <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pwm <= next_pwm;
         period_end <= next_period_end;
      end
   end
endmodule : bgd_pwm_gen

// File: bgd_host_sva.sv
module bgd_host_sva import bgd_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // power stage
   input wire logic supply_good_pin,
   input wire bgd_pins_s pins
);
   // =====================================================
   // cycle counters
   // =====================================================
   // off_cnt starts saturated so the first start after reset is legal
   logic [11:0] wake_cnt, next_wake_cnt, off_cnt, next_off_cnt;
   always_comb begin
      next_wake_cnt = pins.mode_oe ? wake_cnt + 12'h001 : 12'h000;
      next_off_cnt = off_cnt;
      if (pins.mode_oe) begin
         next_off_cnt = 12'h000;
      end else if (off_cnt != 12'hFFF) begin
         next_off_cnt = off_cnt + 12'h001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= 12'h000;
         off_cnt <= 12'hFFF;
      end else begin
         wake_cnt <= next_wake_cnt;
         off_cnt <= next_off_cnt;
      end
   end

   // =====================================================
   // properties
   // =====================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> s_access)
      else $error("no access answer after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_pwm_needs_mode: assert property (
      pins.pwm_oe |-> pins.mode_oe) else $error("pulse driven in shutdown");
   a_enable_wait: assert property (
      $rose(pins.pwm_oe) |-> wake_cnt == ENABLE_CYC)
      else $error("pulse started off the enable delay");
   a_soft_from_zero: assert property (
      $rose(pins.pwm_oe) |-> !pins.pwm_o) else $error("ramp not from zero");
   a_float_together: assert property (
      $fell(pins.pwm_oe) |-> $fell(pins.mode_oe))
      else $error("pins not released together");
   a_shutdown_gap: assert property (
      $rose(pins.mode_oe) |-> off_cnt >= SHUTDOWN_CYC)
      else $error("restart inside shutdown delay");
   a_mode_held: assert property (
      pins.mode_oe && $past(pins.mode_oe) |-> $stable(pins.mode_o))
      else $error("mode level changed while driven");
endmodule : bgd_host_sva

// File: bgd_stage_model.sv
module bgd_stage_model import bgd_pkg::*; (
   // supply and pins
   input wire logic vcc_ok,
   input wire bgd_pins_s pins,
   // supply good and decoded gates
   output logic supply_good_pin,
   output logic high_side_gate,
   output logic low_side_gate
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLDOFF_NS = 150;
   logic active = 1'b0;
   logic ccm = 1'b0;
   logic pwm_live = 1'b0;
   logic pwm_lvl = 1'b0;
   assign supply_good_pin = vcc_ok;
   // mode level is latched when the pin is first driven
   always @(posedge pins.mode_oe) begin
      ccm = pins.mode_o;
      #(ENABLE_DELAY_NS - 100) active = pins.mode_oe;
   end
   // gates drop at once, well inside the shutdown delay
   always @(negedge pins.mode_oe) active = 1'b0;
   // a floated pulse pin keeps its last level through the hold-off
   always @(pins) begin
      if (pins.pwm_oe) begin
         pwm_live = 1'b1;
         pwm_lvl = pins.pwm_o;
      end
   end
   always @(negedge pins.pwm_oe) begin
      #(HOLDOFF_NS) pwm_live = pins.pwm_oe;
   end
   // zero current taken as reached at once: low side stays off in dcm
   assign high_side_gate = vcc_ok && active && pwm_live
      && pwm_lvl;
   assign low_side_gate = vcc_ok && active && ccm
      && pwm_live && !pwm_lvl;
endmodule : bgd_stage_model

// File: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bgd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic vcc_ok, sg, hs, ls;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   bgd_pins_s pins;
   int mismatches, checks;
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   bgd_host_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_good_pin(sg), .pins(pins));
   bgd_stage_model u_stage (.vcc_ok(vcc_ok), .pins(pins),
      .supply_good_pin(sg), .high_side_gate(hs), .low_side_gate(ls));
   // =====================================================
   // helpers
   // =====================================================
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic st_is(input logic [2:0] s);
      logic [31:0] r;
      logic e;
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk({29'h0, r[2:0]}, {29'h0, s});
   endtask : st_is
   // polls status; each poll costs three cycles
   task automatic wait_st(input logic [2:0] s, input int lim);
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, r, e);
         n++;
      end while (r[2:0] !== s && n < lim);
      if (r[2:0] !== s) begin
         chk({29'h0, r[2:0]}, {29'h0, s});
         tally_and_finish();
      end
   endtask : wait_st
   task automatic gates(input int cyc, input int eh, input int el);
      int nh, nl;
      nh = 0;
      nl = 0;
      repeat (cyc) begin
         @(posedge pclk);
         nh += int'(hs === 1'b1);
         nl += int'(ls === 1'b1);
         if (hs === 1'b1 && ls === 1'b1) chk(32'h3, 32'h0);
      end
      chk(nh, eh);
      chk(nl, el);
   endtask : gates
   // =====================================================
   // scenarios
   // =====================================================
   task automatic t_regs();
      logic [7:0] a [5];
      logic [31:0] x [5];
      logic [31:0] r;
      logic e;
      a = '{OFS_CTRL, OFS_PERIOD, OFS_DUTY, OFS_STEP, 8'h20};
      x = '{32'h0, 32'h000000F9, 32'h0, 32'h00000001, 32'h0};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, a[i], 32'h0, r, e);
         chk(r, x[i]);
         chk({31'h0, e}, {31'h0, i == 4});
      end
   endtask : t_regs
   task automatic t_ccm();
      wr(OFS_PERIOD, 32'h00000009);
      wr(OFS_DUTY, 32'h00000005);
      wr(OFS_CTRL, 32'h00000003);
      st_is(ST_WAKE);
      gates(100, 0, 0);
      wait_st(ST_RUN, 600);
      gates(20, 10, 10);
      wr(OFS_CTRL, 32'h00000000);
      st_is(ST_STOP);
      gates(10, 0, 0);
      wait_st(ST_OFF, 300);
   endtask : t_ccm
   task automatic t_dcm_lockout();
      vcc_ok <= 1'b0;
      wr(OFS_CTRL, 32'h00000001);
      repeat (20) @(posedge pclk);
      st_is(ST_OFF);
      vcc_ok <= 1'b1;
      wait_st(ST_RUN, 600);
      gates(20, 10, 0);
      vcc_ok <= 1'b0;
      repeat (5) @(posedge pclk);
      st_is(ST_STOP);
      gates(10, 0, 0);
   endtask : t_dcm_lockout
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      vcc_ok = 1'b1;
      mismatches = 0;
      checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ccm();
      t_dcm_lockout();
      tally_and_finish();
   end
endmodule : tb
bind bgd_host_ctrl bgd_host_sva u_sva (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .supply_good_pin(supply_good_pin), .pins(pins));
